// [hw/nstg_pkg.sv]
// Package: register map, field layout and strobe phase types of the NAND strobe timing block
package nstg_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] TIMING_CONFIG_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [31:0] TIMING_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMING_CONFIG_MASK = 32'h03FF_FFFF;
    // ------------------------------------------------------------
    // Field layout of nand_timing_config
    // ------------------------------------------------------------
    localparam int WR_LOW_LSB = 0;
    localparam int WR_HIGH_LSB = 4;
    localparam int RD_LOW_LSB = 8;
    localparam int RD_HIGH_LSB = 12;
    localparam int TURNAROUND_LSB = 16;
    localparam int BUSY_DELAY_LSB = 19;
    localparam int CE_LEAD_LSB = 24;
    localparam int NIBBLE_W = 4;
    localparam int TURNAROUND_W = 3;
    localparam int BUSY_DELAY_W = 5;
    localparam int CE_LEAD_W = 2;
    localparam int CNT_W = 6;
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int ST_IDLE_BIT = 0;
    localparam int ST_RB_VALID_BIT = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_BUS_FREE_BIT = 3;

    typedef enum logic [2:0] {
        NSTG_IDLE,
        NSTG_CE_LEAD,
        NSTG_LOW,
        NSTG_HIGH,
        NSTG_TURN
    } nstg_phase_t;

    typedef struct packed {
        logic [CE_LEAD_W-1:0] ce_lead;
        logic [BUSY_DELAY_W-1:0] busy_delay;
        logic [TURNAROUND_W-1:0] turnaround;
        logic [NIBBLE_W-1:0] rd_high;
        logic [NIBBLE_W-1:0] rd_low;
        logic [NIBBLE_W-1:0] wr_high;
        logic [NIBBLE_W-1:0] wr_low;
    } nstg_timing_t;
endpackage : nstg_pkg

// [hw/nstg_top.sv]
// Top module: APB timing register and read/write strobe phase generator for NAND flash
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module nstg_top (
    // Clock, reset, enable
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Cycle requests from the controller
    input wire logic RD_REQ,
    input wire logic WR_REQ,
    output logic REQ_ACK,
    output logic CYCLE_DONE,
    // Flash strobes
    output logic CE_N,
    output logic RE_N,
    output logic WE_N,
    output logic BUS_FREE,
    input wire logic RB_IN,
    // Ready/busy back to the controller
    output logic RB_VALID,
    output logic FLASH_READY
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    nstg_pkg::nstg_timing_t cfg_r;
    nstg_pkg::nstg_phase_t phase_r;
    logic [nstg_pkg::CNT_W-1:0] cnt_r;
    logic [nstg_pkg::BUSY_DELAY_W-1:0] busy_cnt_r;
    logic is_rd_r;
    logic wr_hit;
    logic rd_hit_cfg;
    logic rd_hit_st;
    logic access;

    assign access = PSEL && PENABLE && CLK_EN;
    assign wr_hit = access && PWRITE && (PADDR == nstg_pkg::TIMING_CONFIG_ADDR);
    assign rd_hit_cfg = PADDR == nstg_pkg::TIMING_CONFIG_ADDR;
    assign rd_hit_st = PADDR == nstg_pkg::STATUS_ADDR;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_r <= nstg_pkg::nstg_timing_t'(nstg_pkg::TIMING_CONFIG_RESET);
        end else if (wr_hit) begin
            cfg_r <= nstg_pkg::nstg_timing_t'(PWDATA & nstg_pkg::TIMING_CONFIG_MASK);
        end
    end

    // Zero-wait slave: PREADY is registered from the setup cycle and is high in the first access cycle, so the access phase ends at once
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CLK_EN) begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !rd_hit_cfg && !rd_hit_st;
            PRDATA <= 32'h0000_0000;
            if (PSEL && !PENABLE && !PWRITE) begin
                if (rd_hit_cfg) begin
                    PRDATA <= 32'(cfg_r);
                end else if (rd_hit_st) begin
                    PRDATA[nstg_pkg::ST_IDLE_BIT] <= phase_r == nstg_pkg::NSTG_IDLE;
                    PRDATA[nstg_pkg::ST_RB_VALID_BIT] <= RB_VALID;
                    PRDATA[nstg_pkg::ST_READY_BIT] <= FLASH_READY;
                    PRDATA[nstg_pkg::ST_BUS_FREE_BIT] <= BUS_FREE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Strobe phase sequencer
    // ------------------------------------------------------------
    logic [nstg_pkg::CNT_W-1:0] low_len;
    logic [nstg_pkg::CNT_W-1:0] high_len;
    logic [nstg_pkg::CNT_W-1:0] turn_len;

    // Lengths count the cycles of each phase; a zero-length phase is skipped
    always_comb begin
        low_len = is_rd_r ? nstg_pkg::CNT_W'(cfg_r.rd_low) + 1'b1
                          : nstg_pkg::CNT_W'(cfg_r.wr_low) + 1'b1;
        // Negative differences are clamped to zero rather than wrapping
        if (is_rd_r) begin
            high_len = (cfg_r.rd_high > cfg_r.rd_low)
                     ? nstg_pkg::CNT_W'(cfg_r.rd_high - cfg_r.rd_low) : '0;
        end else begin
            high_len = (cfg_r.wr_high > cfg_r.wr_low)
                     ? nstg_pkg::CNT_W'(cfg_r.wr_high - cfg_r.wr_low) : '0;
        end
        turn_len = is_rd_r ? nstg_pkg::CNT_W'(cfg_r.turnaround) : '0;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_r <= nstg_pkg::NSTG_IDLE;
            cnt_r <= '0;
            is_rd_r <= 1'b0;
            REQ_ACK <= 1'b0;
            CYCLE_DONE <= 1'b0;
        end else if (CLK_EN) begin
            REQ_ACK <= 1'b0;
            CYCLE_DONE <= 1'b0;
            unique case (phase_r)
                nstg_pkg::NSTG_IDLE: begin
                    if (RD_REQ || WR_REQ) begin
                        // Read wins when both arrive together
                        is_rd_r <= RD_REQ;
                        REQ_ACK <= 1'b1;
                        if (RD_REQ && cfg_r.ce_lead != '0) begin
                            phase_r <= nstg_pkg::NSTG_CE_LEAD;
                            cnt_r <= nstg_pkg::CNT_W'(cfg_r.ce_lead) - 1'b1;
                        end else begin
                            phase_r <= nstg_pkg::NSTG_LOW;
                            cnt_r <= '0;
                        end
                    end
                end
                nstg_pkg::NSTG_CE_LEAD: begin
                    if (cnt_r == '0) begin
                        phase_r <= nstg_pkg::NSTG_LOW;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                nstg_pkg::NSTG_LOW: begin
                    if (cnt_r == low_len - 1'b1) begin
                        cnt_r <= '0;
                        if (high_len != '0) begin
                            phase_r <= nstg_pkg::NSTG_HIGH;
                        end else if (turn_len != '0) begin
                            phase_r <= nstg_pkg::NSTG_TURN;
                        end else begin
                            phase_r <= nstg_pkg::NSTG_IDLE;
                            CYCLE_DONE <= 1'b1;
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                nstg_pkg::NSTG_HIGH: begin
                    if (cnt_r == high_len - 1'b1) begin
                        cnt_r <= '0;
                        if (turn_len != '0) begin
                            phase_r <= nstg_pkg::NSTG_TURN;
                        end else begin
                            phase_r <= nstg_pkg::NSTG_IDLE;
                            CYCLE_DONE <= 1'b1;
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                nstg_pkg::NSTG_TURN: begin
                    if (cnt_r == turn_len - 1'b1) begin
                        cnt_r <= '0;
                        phase_r <= nstg_pkg::NSTG_IDLE;
                        CYCLE_DONE <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    phase_r <= nstg_pkg::NSTG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered strobe pins
    // ------------------------------------------------------------
    logic next_low;
    logic busy_start;
    always_comb begin
        next_low = 1'b0;
        unique case (phase_r)
            nstg_pkg::NSTG_IDLE: next_low = (RD_REQ || WR_REQ) &&
                                            !(RD_REQ && cfg_r.ce_lead != '0);
            nstg_pkg::NSTG_CE_LEAD: next_low = cnt_r == '0;
            nstg_pkg::NSTG_LOW: next_low = cnt_r != low_len - 1'b1;
            default: next_low = 1'b0;
        endcase
    end
    // Strobe rises when the low phase ends
    assign busy_start = phase_r == nstg_pkg::NSTG_LOW && cnt_r == low_len - 1'b1;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CE_N <= 1'b1;
            RE_N <= 1'b1;
            WE_N <= 1'b1;
            BUS_FREE <= 1'b1;
        end else if (CLK_EN) begin
            // CE falls on the request edge so the lead phase counts from it
            CE_N <= !(phase_r != nstg_pkg::NSTG_IDLE || RD_REQ || WR_REQ) || CYCLE_DONE
                    ? !(RD_REQ || WR_REQ) || phase_r != nstg_pkg::NSTG_IDLE : 1'b0;
            RE_N <= !(next_low && (phase_r == nstg_pkg::NSTG_IDLE ? RD_REQ : is_rd_r));
            WE_N <= !(next_low && (phase_r == nstg_pkg::NSTG_IDLE ? !RD_REQ : !is_rd_r));
            BUS_FREE <= phase_r == nstg_pkg::NSTG_IDLE && !(RD_REQ || WR_REQ);
        end
    end

    // ------------------------------------------------------------
    // Ready/busy qualification
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_cnt_r <= '0;
            RB_VALID <= 1'b1;
            FLASH_READY <= 1'b1;
        end else if (CLK_EN) begin
            if (busy_start) begin
                busy_cnt_r <= cfg_r.busy_delay;
                RB_VALID <= cfg_r.busy_delay == '0;
            end else if (busy_cnt_r > nstg_pkg::BUSY_DELAY_W'(1)) begin
                busy_cnt_r <= busy_cnt_r - 1'b1;
            end else if (busy_cnt_r != '0) begin
                busy_cnt_r <= '0;
                RB_VALID <= 1'b1;
            end
            if (RB_VALID || (busy_cnt_r == nstg_pkg::BUSY_DELAY_W'(1) && !busy_start)) begin
                FLASH_READY <= RB_IN;
            end
        end
    end
endmodule // nstg_top

// [tb/nstg_asserts.sv]
// Checker: strobe phase and ready/busy timing seen at the top ports
`timescale 1ns/10ps
module nstg_asserts (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic PREADY,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    // Strobes and status
    input wire logic CE_N,
    input wire logic RE_N,
    input wire logic WE_N,
    input wire logic BUS_FREE,
    input wire logic RB_VALID
);
    logic [31:0] cfg_r;
    logic [5:0] lead_r, low_r, hi_r;
    logic rd_r;
    nstg_pkg::nstg_timing_t t;
    assign t = cfg_r[25:0];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_r <= 32'h0;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000) begin
            cfg_r <= PWDATA;
        end
    end
    // High count saturates so idle gaps never look short
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lead_r <= 6'h0;
            low_r <= 6'h0;
            hi_r <= 6'h3F;
            rd_r <= 1'b0;
        end else begin
            lead_r <= (!CE_N && RE_N) ? lead_r + 6'h1 : 6'h0;
            low_r <= (!RE_N || !WE_N) ? low_r + 6'h1 : 6'h0;
            hi_r <= (!RE_N || !WE_N) ? 6'h0 : (hi_r == 6'h3F ? hi_r : hi_r + 6'h1);
            rd_r <= !RE_N ? 1'b1 : (!WE_N ? 1'b0 : rd_r);
        end
    end
    ce_lead_a: assert property ($fell(RE_N) |-> lead_r == t.ce_lead)
        else $error("read strobe lead wrong");
    re_low_a: assert property ($rose(RE_N) |-> low_r == t.rd_low + 6'h1)
        else $error("read strobe low width wrong");
    re_high_a: assert property ($rose(BUS_FREE) && rd_r |->
        int'(hi_r) <= int'(t.rd_high) - int'(t.rd_low) + int'(t.turnaround) + 1)
        else $error("read strobe high too long");
    rd_turn_a: assert property ($rose(BUS_FREE) && rd_r |->
        int'(hi_r) >= int'(t.rd_high) - int'(t.rd_low) + int'(t.turnaround))
        else $error("bus freed early after read");
    we_low_a: assert property ($rose(WE_N) |-> low_r == t.wr_low + 6'h1)
        else $error("write strobe low width wrong");
    we_high_a: assert property ($rose(BUS_FREE) && !rd_r |->
        int'(hi_r) >= int'(t.wr_high) - int'(t.wr_low))
        else $error("write strobe high too short");
    rb_delay_a: assert property ($rose(RB_VALID) |-> hi_r == t.busy_delay)
        else $error("ready/busy qualified at wrong time");
    apb_ready_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("register access not answered");
endmodule // nstg_asserts

// [tb/nstg_flash_model.sv]
// Flash ready/busy model driven from the strobe pins
`timescale 1ns/10ps
module nstg_flash_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Strobes and busy lag
    input wire logic re_n,
    input wire logic we_n,
    input wire logic [4:0] lag,
    // Ready/busy, pulled up when released
    output logic rb
);
    logic [5:0] cnt_r;
    logic [5:0] age;
    logic up_r;
    logic rise;
    // Age 0 is the cycle in which the strobe is back high, so a lag of
    // delay minus one is already visible at the controller's sampling edge
    assign rise = re_n & we_n & !up_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 6'h3F;
            up_r <= 1'b1;
        end else begin
            up_r <= re_n & we_n;
            if (rise) cnt_r <= 6'h01;
            else if (cnt_r != 6'h3F) cnt_r <= cnt_r + 6'h01;
        end
    end
    assign age = rise ? 6'h00 : cnt_r;
    // Goes busy lag cycles after a strobe rises, frees after eight
    assign rb = !(age >= {1'b0, lag} && age < {1'b0, lag} + 6'h08);
endmodule // nstg_flash_model

// [tb/nstg_top_test.sv]
// Testbench: register access and strobe timing cycles
`timescale 1ns/10ps
module nstg_top_test;
    logic REF_CLK = 0, RST_B = 0, CLK_EN = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic RD_REQ = 0, WR_REQ = 0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, REQ_ACK, CYCLE_DONE, CE_N, RE_N, WE_N, BUS_FREE, RB_IN;
    logic RB_VALID, FLASH_READY;
    logic [4:0] lag = 5'h00;
    logic [31:0] cfgs [4] = '{32'h0000_0000, 32'h012F_FFFF, 32'h02FB_9261, 32'h0309_4033};
    int miscompares = 0, n_tests = 0, cyc = 0;
    nstg_top DUT (
        .REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .RD_REQ(RD_REQ), .WR_REQ(WR_REQ), .REQ_ACK(REQ_ACK), .CYCLE_DONE(CYCLE_DONE),
        .CE_N(CE_N), .RE_N(RE_N), .WE_N(WE_N), .BUS_FREE(BUS_FREE), .RB_IN(RB_IN),
        .RB_VALID(RB_VALID), .FLASH_READY(FLASH_READY)
    );
    nstg_flash_model FM (.clk(REF_CLK), .rst_b(RST_B), .re_n(RE_N), .we_n(WE_N), .lag(lag),
        .rb(RB_IN));
    initial forever #10 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic err);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // The write request is still high at the edge after the cycle is taken and must be refused
    task automatic run(input logic rd, input logic [31:0] c);
        int lead, low, falls, busy, acks, dones, rbv, nrdy, hi, n;
        logic s, p;
        lead = 0;
        low = 0;
        falls = 0;
        busy = 0;
        acks = 0;
        dones = 0;
        rbv = 0;
        nrdy = 0;
        p = 1'b1;
        hi = rd ? int'(c[15:12]) - int'(c[11:8]) : int'(c[7:4]) - int'(c[3:0]);
        if (hi < 0) hi = 0;
        @(posedge REF_CLK);
        RD_REQ <= rd;
        WR_REQ <= 1'b1;
        // Window covers the longest cycle, and the longest busy delay and busy time counted from the strobe rise
        for (n = 0; n < 64; n++) begin
            @(posedge REF_CLK);
            if (acks != 0) begin
                RD_REQ <= 1'b0;
                WR_REQ <= 1'b0;
            end
            @(negedge REF_CLK);
            s = rd ? RE_N : WE_N;
            if (!CE_N && s && falls == 0) lead++;
            if (!s && p) falls++;
            if (!s && falls == 1) low++;
            if ((rd ? WE_N : RE_N) !== 1'b1) falls = 9;
            if (!CE_N && !CYCLE_DONE) busy++;
            if (REQ_ACK) acks++;
            if (CYCLE_DONE) dones++;
            if (!RB_VALID) rbv++;
            if (!FLASH_READY) nrdy++;
            p = s;
        end
        chk("strobe lead", rd ? c[25:24] : 2'b00, lead);
        chk("strobe low", (rd ? c[11:8] : c[3:0]) + 1, low);
        chk("cycle length",
            (rd ? c[25:24] + c[11:8] + c[18:16] : c[3:0]) + 1 + hi, busy);
        chk("pulses", 1, falls);
        chk("request acks", 1, acks);
        chk("cycle done", 1, dones);
        chk("busy delay", c[23:19], rbv);
        chk("busy seen", 8, nrdy);
        $display("cycle test done read=%0b", rd);
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        repeat (4) @(posedge REF_CLK);
        RST_B <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk("config reset", 32'h0, r);
        apb(1'b1, nstg_pkg::STATUS_ADDR, 32'h0, r, e);
        apb(1'b0, nstg_pkg::STATUS_ADDR, 32'h0, r, e);
        chk("status idle", 32'hF, r);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk("unmapped error", 1'b1, e);
        chk("unmapped data", 32'h0, r);
        $display("register test done");
        foreach (cfgs[i]) begin
            apb(1'b1, 12'h000, 32'hFC00_0000 | cfgs[i], r, e);
            apb(1'b0, 12'h000, 32'h0, r, e);
            chk("config readback", cfgs[i], r);
            chk("config error", 1'b0, e);
            lag <= (cfgs[i][23:19] == 5'h00) ? 5'h00 : cfgs[i][23:19] - 5'h01;
            run(1'b1, cfgs[i]);
            run(1'b0, cfgs[i]);
        end
        @(posedge REF_CLK);
        CLK_EN <= 1'b0;
        RD_REQ <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        chk("frozen chip enable", 1'b1, CE_N);
        chk("frozen ack", 1'b0, REQ_ACK);
        chk("frozen bus free", 1'b1, BUS_FREE);
        RD_REQ <= 1'b0;
        CLK_EN <= 1'b1;
        $display("freeze test done");
        repeat (60) @(posedge REF_CLK);
        apb(1'b0, nstg_pkg::STATUS_ADDR, 32'h0, r, e);
        chk("status ready", 32'hF, r);
        report_and_stop();
    end
endmodule // nstg_top_test

bind nstg_top nstg_asserts CHK (
    .REF_CLK(REF_CLK), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY),
    .PADDR(PADDR), .PWDATA(PWDATA),
    .CE_N(CE_N), .RE_N(RE_N), .WE_N(WE_N), .BUS_FREE(BUS_FREE), .RB_VALID(RB_VALID)
);
